// *** logic/power_mode_clock_divider.sv ***
// Purpose: Sleep and idle control, wake decision and peripheral bus clock divider
// Assumes: Requests and control come from logic on clk; no software registers
// Notes: Peripheral bus clock is delivered as a clock-enable pulse on clk
//
// Overview of operation
// - Sleep wakes on enabled sleep-capable interrupt above current priority.
// - Sleep interrupt at or below priority keeps core halted, enters idle.
// - Any device reset ends sleep and idle, returns to run.
// - Watchdog time-out ends sleep; watchdog interrupt ends idle; core restarts.
// - Idle halts the core yet keeps the system clock running.
// - Peripherals with stop_in_idle set stop on idle entry.
// - Wait with sleep_enable_bit clear enters idle rather than sleep.
// - Idle wakes on interrupt above priority or watchdog interrupt, else stays idle.
// - Divisor field selects peripheral clock as system clock over 1,2,4,8.
// - Divisor changes only the peripheral clock, not the system clock users.
// - Peripheral read completes on next peripheral clock edge.
// - Start-up delay when switching to disabled crystal source; none leaving idle.
// - stop_in_idle set suspends a peripheral during idle, clear continues.
`timescale 1ns/1ns
module power_mode_clock_divider
  import power_mode_pkg::*;
#(
  parameter int NPER = power_mode_pkg::NUM_PERIPH
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic waitExec,
  input wire logic sleepEnableBit,
  input wire logic [power_mode_pkg::DIV_W-1:0] peripheralClockDivisor,
  input wire logic intValid,
  input wire logic intRunsInSleep,
  input wire logic [power_mode_pkg::PRIO_W-1:0] intPriority,
  input wire logic [power_mode_pkg::PRIO_W-1:0] cpuPriority,
  input wire logic watchdogTimeout,
  input wire logic watchdogInt,
  input wire logic switchToCrystal,
  input wire logic [NPER-1:0] stopInIdle,
  input wire logic readReq,
  output logic cpuHalt,
  output logic inIdle,
  output logic inSleep,
  output logic sysClockRun,
  output logic periphClkEn,
  output logic [NPER-1:0] periphRun,
  output logic readDone
);
  import power_mode_pkg::*;

  // Elaboration checks on sizes the logic relies on
  if (NPER < 1)
  begin : gen_nper_check
    $error("NPER must be at least one");
  end
  if (STARTUP_CYCLES >= (1 << STARTUP_W))
  begin : gen_startup_check
    $error("start-up count does not fit its counter");
  end
  if (CNT_W < (1 << DIV_W) - 1)
  begin : gen_div_check
    $error("divider counter too narrow for the largest divisor");
  end

  power_state_t state_reg, state_next;
  logic [STARTUP_W-1:0] startCnt_reg, startCnt_next;
  logic [CNT_W-1:0] divCnt_reg, divCnt_next;
  logic [DIV_W-1:0] divSel_reg, divSel_next;
  logic periphClkEn_reg, periphClkEn_next;
  logic readPend_reg, readPend_next;
  logic readDone_reg, readDone_next;
  logic [NPER-1:0] periphRun_reg, periphRun_next;
  logic wakeSleep, wakeIdle, intAbove;
  logic [CNT_W-1:0] divLast;
  logic cpuHalt_reg, cpuHalt_next;
  logic inIdle_reg, inIdle_next;
  logic inSleep_reg, inSleep_next;
  logic sysClockRun_reg, sysClockRun_next;

  assign intAbove = intValid && (intPriority > cpuPriority);
  assign wakeSleep = watchdogTimeout || (intAbove && intRunsInSleep);
  assign wakeIdle = watchdogInt || intAbove;

  always_comb
  begin
    state_next = state_reg;
    startCnt_next = startCnt_reg;
    unique case (state_reg)
      RUN_S:
      begin
        if (switchToCrystal)
        begin
          state_next = START_S;
          startCnt_next = STARTUP_W'(STARTUP_CYCLES);
        end
        else if (waitExec)
        begin
          state_next = sleepEnableBit ? SLEEP_S : IDLE_S;
        end
      end
      IDLE_S:
      begin
        if (wakeIdle)
        begin
          state_next = RUN_S;
        end
      end
      SLEEP_S:
      begin
        if (wakeSleep)
        begin
          state_next = RUN_S;
        end
        else if (intValid && intRunsInSleep)
        begin
          state_next = IDLE_S;
        end
      end
      START_S:
      begin
        if (startCnt_reg <= STARTUP_W'(1))
        begin
          state_next = RUN_S;
          startCnt_next = '0;
        end
        else
        begin
          startCnt_next = startCnt_reg - STARTUP_W'(1);
        end
      end
      default:
      begin
        state_next = RUN_S;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= RUN_S;
      startCnt_reg <= '0;
    end
    else if (clkEn)
    begin
      state_reg <= state_next;
      startCnt_reg <= startCnt_next;
    end
  end

  // Divider: divisor is taken only at the end of a full period
  always_comb
  begin
    divLast = CNT_W'((1 << divSel_reg) - 1);
    divSel_next = divSel_reg;
    divCnt_next = divCnt_reg + CNT_W'(1);
    periphClkEn_next = 1'b0;
    if (state_reg == SLEEP_S)
    begin
      divCnt_next = '0;
    end
    else if (divCnt_reg >= divLast)
    begin
      divCnt_next = '0;
      periphClkEn_next = 1'b1;
      divSel_next = peripheralClockDivisor;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divCnt_reg <= '0;
      divSel_reg <= DIV_RESET;
      periphClkEn_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      divCnt_reg <= divCnt_next;
      divSel_reg <= divSel_next;
      periphClkEn_reg <= periphClkEn_next;
    end
  end

  // Peripheral gating and read completion
  always_comb
  begin
    readPend_next = readPend_reg;
    readDone_next = 1'b0;
    if (state_next == IDLE_S)
    begin
      periphRun_next = ~stopInIdle;
    end
    else if (state_next == RUN_S)
    begin
      periphRun_next = {NPER{1'b1}};
    end
    else
    begin
      periphRun_next = '0;
    end
    if (readReq)
    begin
      readPend_next = 1'b1;
    end
    if ((readPend_reg || readReq) && periphClkEn_next)
    begin
      readDone_next = 1'b1;
      readPend_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      periphRun_reg <= '1;
      readPend_reg <= 1'b0;
      readDone_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      periphRun_reg <= periphRun_next;
      readPend_reg <= readPend_next;
      readDone_reg <= readDone_next;
    end
  end

  // Status outputs decode the next state so that each one leaves a flop
  always_comb
  begin
    cpuHalt_next = (state_next != RUN_S);
    inIdle_next = (state_next == IDLE_S);
    inSleep_next = (state_next == SLEEP_S);
    sysClockRun_next = (state_next != SLEEP_S);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpuHalt_reg <= 1'b0;
      inIdle_reg <= 1'b0;
      inSleep_reg <= 1'b0;
      sysClockRun_reg <= 1'b1;
    end
    else if (clkEn)
    begin
      cpuHalt_reg <= cpuHalt_next;
      inIdle_reg <= inIdle_next;
      inSleep_reg <= inSleep_next;
      sysClockRun_reg <= sysClockRun_next;
    end
  end

  assign cpuHalt = cpuHalt_reg;
  assign inIdle = inIdle_reg;
  assign inSleep = inSleep_reg;
  assign sysClockRun = sysClockRun_reg;
  assign periphClkEn = periphClkEn_reg;
  assign periphRun = periphRun_reg;
  assign readDone = readDone_reg;

  AST_IDLE_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && state_reg == RUN_S && waitExec && !switchToCrystal && !sleepEnableBit)
    |=> state_reg == IDLE_S)
    else $error("wait with sleep disabled did not enter idle");
  AST_SLEEP_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && inSleep && intAbove && intRunsInSleep) |=> state_reg == RUN_S)
    else $error("sleep did not wake on higher priority interrupt");
  AST_SLEEP_TO_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && inSleep && intValid && intRunsInSleep && !intAbove && !watchdogTimeout)
    |=> inIdle && cpuHalt)
    else $error("low priority sleep interrupt did not move to idle");
  AST_WDT_SLEEP: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && inSleep && watchdogTimeout) |=> !cpuHalt)
    else $error("watchdog time-out did not end sleep");
  AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && inIdle && !intAbove && !watchdogInt) |=> inIdle)
    else $error("idle left without a wake event");
  AST_IDLE_CLOCK: assert property (@(posedge clk) disable iff (!rst_n)
    inIdle |-> sysClockRun && cpuHalt)
    else $error("idle stopped the system clock");
  AST_STOP_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && inIdle && $past(inIdle) && $past(clkEn)) |-> periphRun == ~$past(stopInIdle))
    else $error("peripheral gating in idle is wrong");
  AST_DIV_PERIOD: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && periphClkEn && divSel_reg == 2'h1 && !inSleep) |=> !periphClkEn)
    else $error("divide by two gave back to back pulses");
  AST_READ_DONE: assert property (@(posedge clk) disable iff (!rst_n)
    readDone |-> periphClkEn)
    else $error("read completed off a peripheral clock edge");
  AST_IDLE_PERIPHERAL_BUS_CLOCK: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && inIdle && divSel_reg == 2'h0 && $past(clkEn) && $past(inIdle))
    |-> periphClkEn)
    else $error("peripheral clock stopped in idle");
  AST_IDLE_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && inIdle && wakeIdle) |=> !cpuHalt)
    else $error("leaving idle took a start-up delay");
  AST_START_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && state_reg == START_S && startCnt_reg > STARTUP_W'(1)) |=> cpuHalt)
    else $error("core restarted before the start-up delay ran out");
  AST_START_END: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && state_reg == START_S && startCnt_reg == STARTUP_W'(1)) |=> !cpuHalt)
    else $error("start-up delay did not end on time");
endmodule

// *** logic/power_mode_pkg.sv ***
// Purpose: Shared constants for the power mode and peripheral clock divider
// Assumes: One system clock domain
// Notes: Priorities are 3-bit levels, zero means no request
package power_mode_pkg;
  localparam int PRIO_W = 3;
  localparam int DIV_W = 2;
  localparam int NUM_PERIPH = 4;
  localparam int SLEEP_EN_POS = 4;
  localparam int DIV_LSB_POS = 19;
  localparam int DIV_MSB_POS = 20;
  localparam int CNT_W = 3;
  localparam logic [DIV_W-1:0] DIV_RESET = 2'h0;
  localparam int STARTUP_NS = 1000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_W = 8;
  typedef enum logic [3:0]
  {
    RUN_S = 4'h1,
    IDLE_S = 4'h2,
    SLEEP_S = 4'h4,
    START_S = 4'h8
  } power_state_t;
endpackage

// *** verif/periph_model.sv ***
// Purpose: Peripherals on the divided clock, counting their clock edges
// Assumes: Clock edges arrive as enable pulses on clk
// Notes: A stopped peripheral holds its count
`timescale 1ns/1ns
module periph_model
  import power_mode_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic periphClkEn,
  input wire logic [power_mode_pkg::NUM_PERIPH-1:0] periphRun,
  output logic [power_mode_pkg::NUM_PERIPH-1:0][7:0] ticks
);
  import power_mode_pkg::*;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ticks <= '0;
    else
      for (int i = 0; i < NUM_PERIPH; i++)
        if (periphClkEn && periphRun[i])
          ticks[i] <= ticks[i] + 8'h01;
  end
endmodule

// *** verif/tb_power_mode_clock_divider.sv ***
// Purpose: Self-checking bench for power modes and the peripheral divider
// Assumes: One clock at 100 ns, core priority held at 3
// Notes: Pulses are sampled at the clock edge, states 1 ns after it
`timescale 1ns/1ns
module tb_power_mode_clock_divider;
  import power_mode_pkg::*;
  logic clk = 0, rst_n = 0, waitExec = 0, sleepEn = 0, intValid = 0, intSl = 0;
  logic wdTo = 0, wdInt = 0, xtal = 0, readReq = 0, clkEn = 1;
  logic [1:0] div = 0;
  logic [2:0] intPrio = 0, cpuPrio = 3;
  logic [3:0] stopInIdle = 4'h5, periphRun;
  logic cpuHalt, inIdle, inSleep, sysClockRun, periphClkEn, readDone;
  logic [3:0][7:0] ticks;
  int mismatches = 0, checks_done = 0, cycles = 0, n;
  power_mode_clock_divider #(.NPER(4)) dut_u (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
    .waitExec(waitExec), .sleepEnableBit(sleepEn), .peripheralClockDivisor(div),
    .intValid(intValid), .intRunsInSleep(intSl), .intPriority(intPrio),
    .cpuPriority(cpuPrio), .watchdogTimeout(wdTo), .watchdogInt(wdInt),
    .switchToCrystal(xtal), .stopInIdle(stopInIdle), .readReq(readReq),
    .cpuHalt(cpuHalt), .inIdle(inIdle), .inSleep(inSleep), .sysClockRun(sysClockRun),
    .periphClkEn(periphClkEn), .periphRun(periphRun), .readDone(readDone));
  periph_model model_u (.clk(clk), .rst_n(rst_n), .periphClkEn(periphClkEn),
    .periphRun(periphRun), .ticks(ticks));
  initial
  begin
    forever #50 clk = ~clk;
  end
  task automatic conclude();
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 5000)
    begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(string what, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic doWait(logic s);
    @(posedge clk);
    sleepEn <= s;
    waitExec <= 1'b1;
    @(posedge clk);
    waitExec <= 1'b0;
    settle();
  endtask
  task automatic irq(logic [2:0] p, logic s);
    @(posedge clk);
    {intPrio, intSl, intValid} <= {p, s, 1'b1};
    @(posedge clk);
    intValid <= 1'b0;
    settle();
  endtask
  task automatic wd(logic t);
    @(posedge clk);
    {wdTo, wdInt} <= {t, !t};
    @(posedge clk);
    {wdTo, wdInt} <= 2'b00;
    settle();
  endtask
  task automatic nextPulse(logic p);
    n = 0;
    @(posedge clk);
    while ((p ? readDone : periphClkEn) !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
  endtask
  task automatic freeze();
    logic [7:0] t0;
    nextPulse(1'b0);
    clkEn <= 1'b0;
    waitExec <= 1'b1;
    #1;
    t0 = ticks[1];
    repeat (12) @(posedge clk);
    #1;
    chk("frozen", 0, cpuHalt);
    chk("frozenclk", t0, ticks[1]);
    @(posedge clk);
    clkEn <= 1'b1;
    waitExec <= 1'b0;
    settle();
    chk("frozen", 0, cpuHalt);
  endtask
  task automatic resetFrom(logic s);
    doWait(s);
    chk("entered", 1, s ? inSleep : inIdle);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk("resethalt", 0, cpuHalt);
    @(posedge clk);
    rst_n <= 1'b1;
    settle();
    chk("sleep", 0, inSleep);
    chk("idle", 0, inIdle);
    chk("run", 8'h0f, periphRun);
  endtask
  initial
  begin : main
    logic [7:0] t0, t1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    doWait(1'b0);
    chk("idle", 1, inIdle);
    chk("halt", 1, cpuHalt);
    chk("system_clock", 1, sysClockRun);
    chk("run", 8'h0a, periphRun);
    t0 = ticks[0];
    t1 = ticks[1];
    settle();
    chk("stopped", t0, ticks[0]);
    chk("running", 1, ticks[1] != t1);
    irq(3'h3, 1'b0);
    chk("idle", 1, inIdle);
    irq(3'h4, 1'b0);
    chk("halt", 0, cpuHalt);
    chk("run", 8'h0f, periphRun);
    doWait(1'b0);
    wd(1'b0);
    chk("halt", 0, cpuHalt);
    doWait(1'b1);
    chk("sleep", 1, inSleep);
    chk("system_clock", 0, sysClockRun);
    irq(3'h2, 1'b1);
    chk("idle", 1, inIdle);
    chk("halt", 1, cpuHalt);
    irq(3'h5, 1'b1);
    chk("halt", 0, cpuHalt);
    doWait(1'b1);
    irq(3'h5, 1'b1);
    chk("halt", 0, cpuHalt);
    doWait(1'b1);
    wd(1'b1);
    chk("halt", 0, cpuHalt);
    resetFrom(1'b0);
    resetFrom(1'b1);
    for (int d = 0; d < 4; d++)
    begin
      @(posedge clk);
      div <= d[1:0];
      repeat (20) @(posedge clk);
      nextPulse(1'b0);
      nextPulse(1'b0);
      chk("gap", 8'(1 << d), 8'(n + 1));
      @(posedge clk);
      readReq <= 1'b1;
      @(posedge clk);
      readReq <= 1'b0;
      nextPulse(1'b1);
      chk("readlat", 1, n < (1 << d));
      chk("readedge", 1, periphClkEn);
    end
    freeze();
    @(posedge clk);
    xtal <= 1'b1;
    @(posedge clk);
    xtal <= 1'b0;
    repeat (STARTUP_CYCLES - 1) @(posedge clk);
    #1;
    chk("start", 1, cpuHalt);
    @(posedge clk);
    #1;
    chk("start", 0, cpuHalt);
    conclude();
  end
endmodule
